// ### test/testbench.sv
// Self-checking bench for the alarm detector and framer stand-in.
// Assumes four-frame windows of twenty-bit frames.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import tjad_pkg::*;
	localparam int WF = 4;
	logic clock;
	logic rst;
	logic sync_on;
	logic ones;
	logic [2:0] fmt_sel;
	tjad_rx_t rx;
	tjad_bus_t bus;
	logic [7:0] rdata;
	logic [2:0] alarm_state;
	logic irq;
	logic [7:0] rv;
	int n_errors;
	int checks;
	int cyc;
	int nfr;
	event win;
	tjad_framer_model fm (.clock(clock), .rst(rst), .sync_on(sync_on), .ones(ones),
		.fmt(fmt_sel), .rx(rx));
	tjad_alarm_detector #(.WIN_FRAMES(WF)) dut (.clock(clock), .rst(rst), .clk_en(1'b1),
		.rx(rx), .bus(bus), .rdata(rdata), .alarm_state(alarm_state), .irq(irq));
	initial begin
		clock = 1'b0;
		forever #2 clock = !clock;
	end
	task automatic conclude();
		if (n_errors == 0 && checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : conclude
	// Window ends tracked from the framer, never from the design
	always @(posedge clock) begin
		cyc++;
		if (cyc > 10000) begin
			n_errors++;
			conclude();
		end
		if (rx.frame_strobe && !rst) begin
			nfr++;
			if (nfr % WF == 0) begin
				->win;
			end
		end
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		bus <= '{a, d, 1'b1, 1'b0};
		@(posedge clock);
		bus <= '0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clock);
		bus <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clock);
		bus <= '0;
		#1 d = rdata;
	endtask : rd
	// Line changes land on a window edge so every window is clean
	task automatic step(input logic s, input logic o);
		@(win);
		sync_on <= s;
		ones <= o;
	endtask : step
	task automatic win_chk(input logic [2:0] e);
		@(win);
		#1 chk({5'h00, alarm_state}, {5'h00, e});
	endtask : win_chk
	task automatic t_reset();
		logic [7:0] a [11] = '{8'hb9, 8'hba, 8'hbb, 8'hbc, 8'hbd, 8'hbe, 8'hbf, 8'hc0, 8'hc1,
			8'hc8, 8'h00};
		logic [7:0] e [11] = '{8'h00, 8'h00, 8'h00, 8'h3f, 8'h7f, 8'h0a, 8'h0a, 8'h3f, 8'h3f,
			8'h00, 8'h00};
		for (int i = 0; i < 11; i++) begin
			rd(a[i], rv);
			chk(rv, e[i]);
		end
		wr(8'hb9, 8'hff);
		rd(8'hb9, rv);
		chk(rv, 8'h00);
	endtask : t_reset
	task automatic t_blue();
		wr(8'hc0, 8'h02);
		wr(8'hc1, 8'h01);
		wr(8'hba, 8'h07);
		rd(8'hc0, rv);
		chk(rv, 8'h02);
		step(1'b1, 1'b1);
		win_chk(3'h0);
		win_chk(3'h4);
		@(posedge clock);
		#1 chk({7'h00, irq}, 8'h01);
		rd(8'hbb, rv);
		chk(rv, 8'h04);
		wr(8'hbb, 8'h04);
		rd(8'hbb, rv);
		chk(rv, 8'h00);
		chk({7'h00, irq}, 8'h00);
	endtask : t_blue
	task automatic t_yel();
		wr(8'hbe, 8'h01);
		wr(8'hbf, 8'h01);
		step(1'b1, 1'b0);
		win_chk(3'h2);
		step(1'b1, 1'b1);
		win_chk(3'h0);
	endtask : t_yel
	task automatic t_red();
		wr(8'hbc, 8'h02);
		wr(8'hbd, 8'h01);
		step(1'b0, 1'b0);
		win_chk(3'h0);
		win_chk(3'h1);
		step(1'b1, 1'b0);
		win_chk(3'h3);
		win_chk(3'h3);
		win_chk(3'h2);
	endtask : t_red
	task automatic t_fmt();
		logic [5:0] y1 = 6'b011000;
		logic [5:0] y0 = 6'b100101;
		for (int f = 0; f < 6; f++) begin
			wr(8'hc8, 8'(f));
			fmt_sel <= 3'(f);
			step(1'b1, 1'b1);
			@(win);
			#1 chk({7'h00, alarm_state[1]}, {7'h00, y1[f]});
			step(1'b1, 1'b0);
			@(win);
			#1 chk({7'h00, alarm_state[1]}, {7'h00, y0[f]});
		end
	endtask : t_fmt
	initial begin
		rst = 1'b1;
		sync_on = 1'b1;
		ones = 1'b0;
		fmt_sel = 3'h0;
		bus = '0;
		n_errors = 0;
		checks = 0;
		cyc = 0;
		nfr = 0;
		repeat (3) @(posedge clock);
		rst <= 1'b0;
		t_reset();
		t_blue();
		t_yel();
		t_red();
		t_fmt();
		conclude();
	end
endmodule : testbench
`default_nettype wire

// ### test/tjad_alarm_properties.sv
// Port checker for the alarm detector.
// Assumes WIN_FRAMES matches the design instance.
`timescale 1ns/1ps
`default_nettype none
module tjad_alarm_checker #(
	parameter int WIN_FRAMES = 4
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic clk_en,
	input wire tjad_pkg::tjad_rx_t rx,
	input wire tjad_pkg::tjad_bus_t bus,
	input wire logic [7:0] rdata,
	input wire logic [2:0] alarm_state,
	input wire logic irq
);
	import tjad_pkg::*;
	logic [15:0] nfr_reg;
	logic [7:0] zc_reg;
	logic [2:0] en_reg;
	logic win_end;
	logic [7:0] zc_full;
	assign win_end = clk_en && rx.frame_strobe && nfr_reg == 16'(WIN_FRAMES - 1);
	assign zc_full = zc_reg + {7'h00, rx.bit_strobe && !rx.bit_val};
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			nfr_reg <= 16'h0000;
			zc_reg <= 8'h00;
			en_reg <= 3'h0;
		end else if (clk_en) begin
			if (rx.frame_strobe) begin
				nfr_reg <= win_end ? 16'h0000 : nfr_reg + 16'h0001;
			end
			zc_reg <= win_end ? 8'h00 : zc_full;
			if (bus.wr && bus.addr == 8'hba) begin
				en_reg <= bus.wdata[2:0];
			end
		end
	end
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	state_on_window_a: assert property ($changed(alarm_state) |-> $past(win_end))
		else $error("alarm moved off a window end");
	blue_declare_a: assert property ($rose(alarm_state[2]) |-> $past(win_end && zc_full < 8'd61))
		else $error("blue set without a bad window");
	blue_clear_a: assert property ($fell(alarm_state[2]) |-> $past(win_end && zc_full > 8'd60))
		else $error("blue cleared without a good window");
	yellow_sync_a: assert property ($changed(alarm_state[1]) |-> $past(rx.in_sync))
		else $error("yellow moved out of sync");
	red_declare_a: assert property ($rose(alarm_state[0]) |-> !$past(rx.in_sync))
		else $error("red set while in sync");
	red_clear_a: assert property ($fell(alarm_state[0]) |-> $past(rx.in_sync))
		else $error("red cleared while out of sync");
	flag_irq_a: assert property ($changed(alarm_state) &&
		|(en_reg & (alarm_state ^ $past(alarm_state))) |-> ##[1:2] irq)
		else $error("enabled toggle gave no irq");
	irq_masked_a: assert property (en_reg == 3'h0 |-> !irq)
		else $error("irq with all enables off");
	cover property ($rose(alarm_state[0]));
	cover property ($rose(alarm_state[1]));
	cover property ($rose(irq));
endmodule : tjad_alarm_checker
bind tjad_alarm_detector tjad_alarm_checker #(.WIN_FRAMES(WIN_FRAMES)) chk_i (.clock(clock),
	.rst(rst), .clk_en(clk_en), .rx(rx), .bus(bus), .rdata(rdata),
	.alarm_state(alarm_state), .irq(irq));
`default_nettype wire

// ### test/tjad_framer_model.sv
// Receive framer stand-in: fixed frames of flagged bits.
// Assumes the bench steers sync and bit level at window ends.
`timescale 1ns/1ps
`default_nettype none
module tjad_framer_model #(
	parameter int BITS = 20
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic sync_on,
	input wire logic ones,
	input wire logic [2:0] fmt,
	output var tjad_pkg::tjad_rx_t rx
);
	import tjad_pkg::*;
	logic [7:0] ph_reg;
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			ph_reg <= 8'h00;
		end else begin
			ph_reg <= (ph_reg == 8'(BITS + 1)) ? 8'h00 : ph_reg + 8'h01;
		end
	end
	always_comb begin
		rx = '0;
		rx.in_sync = sync_on;
		rx.bit_strobe = ph_reg < 8'(BITS);
		rx.frame_strobe = ph_reg == 8'(BITS + 1);
		// Idle line inverted so a stale value never counts
		rx.bit_val = rx.bit_strobe ? ones : !ones;
		rx.is_dl = 1'b1;
		// Every bit posed as the one each format watches
		rx.is_fbit = (fmt == 3'h3);
		rx.frame_no = 5'd12;
		rx.chan = 5'd24;
		rx.bit_idx = (fmt == 3'h2) ? 3'h5 : 3'h1;
	end
endmodule : tjad_framer_model
`default_nettype wire

// ### verilog/tjad_alarm_detector.sv
// T1/J1 receive alarm detector: blue, yellow and red alarms for one link.
// Assumes the receive framer on the same clock flags each bit and frame start.
//
// What this block does
// - Blue declared: under 61 zeros, N windows
// - Blue cleared: over 60 zeros, M windows
// - Yellow evaluated only while frame synchronized
// - SF/SLC-96: under 77 bit-2 ones declares
// - SF/SLC-96: over 76 bit-2 ones clears
// - ESF: over 7 FF00 patterns declares
// - ESF: under 8 FF00 patterns clears
// - DM: under 4 Y-bit ones declares
// - DM: over 3 Y-bit ones clears
// - J1 SF: under 4 frame-12 F zeros declares
// - J1 SF: over 3 frame-12 F zeros clears
// - J1 ESF: under 3 DL zeros declares
// - J1 ESF: over 2 DL zeros clears
// - Red declared after N windows without sync
// - Red cleared after M times 120 ms sync
// - Separate 8-bit declare and clear thresholds
// - Change flags set on toggles, write-one clears
// - Interrupt while flag and its enable set
//
// Our own choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "tjad_cfg.svh"
module tjad_alarm_detector #(
	parameter int WIN_FRAMES = `TJAD_WIN_FRAMES
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic clk_en,
	input wire tjad_pkg::tjad_rx_t rx,
	input wire tjad_pkg::tjad_bus_t bus,
	output logic [7:0] rdata,
	output logic [2:0] alarm_state,
	output logic irq
);
	import tjad_pkg::*;

	typedef struct packed {
		logic [2:0] enable;
		logic [2:0] flags;
		logic [7:0] red_dth;
		logic [7:0] red_cth;
		logic [7:0] yel_dth;
		logic [7:0] yel_cth;
		logic [7:0] blue_dth;
		logic [7:0] blue_cth;
		logic [2:0] fmt;
		logic [8:0] frame_cnt;
		logic [6:0] zero_cnt;
		logic [7:0] yel_cnt;
		logic lost_all;
		logic sync_all;
		logic [15:0] dl_shift;
		logic [2:0] prev_alarm;
		logic [7:0] rdata;
		logic irq;
	} tjad_state_t;

	tjad_state_t s_reg;
	tjad_state_t s_next;

	logic blue_alarm;
	logic yel_alarm;
	logic red_alarm;
	logic win_end;
	logic blue_bad;
	logic blue_good;
	logic yel_bad;
	logic yel_good;
	logic yel_tick;
	logic red_bad;
	logic red_good;
	logic [6:0] zero_now;
	logic [7:0] yel_now;
	logic [15:0] dl_now;
	logic lost_now;
	logic sync_now;
	logic [2:0] status;
	logic [9:0] red_clr_th;

	localparam logic [8:0] WIN_LAST = 9'(WIN_FRAMES - 1);

	function automatic logic [6:0] sat7(input logic [6:0] v);
		sat7 = (v == 7'h7f) ? v : v + 7'h01;
	endfunction : sat7

	assign status = {blue_alarm, yel_alarm, red_alarm};

	// Window boundary and the counts of the closing window
	always_comb begin
		win_end = rx.frame_strobe && (s_reg.frame_cnt == WIN_LAST);
		zero_now = s_reg.zero_cnt;
		yel_now = s_reg.yel_cnt;
		dl_now = s_reg.dl_shift;
		lost_now = s_reg.lost_all && !rx.in_sync;
		sync_now = s_reg.sync_all && rx.in_sync;
		if (rx.bit_strobe && !rx.bit_val) begin
			zero_now = sat7(s_reg.zero_cnt);
		end
		if (rx.bit_strobe && rx.is_dl) begin
			dl_now = {s_reg.dl_shift[14:0], rx.bit_val};
		end
		// Yellow patterns are only gathered in sync
		if (rx.bit_strobe && rx.in_sync) begin
			case (s_reg.fmt)
				`TJAD_FMT_T1_SF, `TJAD_FMT_SLC96: begin
					if (!rx.is_fbit && rx.bit_idx == `TJAD_BIT2_IDX && rx.bit_val) begin
						yel_now = tjad_sat8(s_reg.yel_cnt);
					end
				end
				`TJAD_FMT_T1_ESF: begin
					// Sliding match, first bit ends in the MSB
					if (rx.is_dl && dl_now == `TJAD_ESF_PATTERN) begin
						yel_now = tjad_sat8(s_reg.yel_cnt);
					end
				end
				`TJAD_FMT_T1_DM: begin
					if (!rx.is_fbit && rx.chan == `TJAD_YBIT_CHAN
						&& rx.bit_idx == `TJAD_YBIT_IDX && rx.bit_val) begin
						yel_now = tjad_sat8(s_reg.yel_cnt);
					end
				end
				`TJAD_FMT_J1_SF: begin
					if (rx.is_fbit && rx.frame_no == `TJAD_J1_FRAME && !rx.bit_val) begin
						yel_now = tjad_sat8(s_reg.yel_cnt);
					end
				end
				`TJAD_FMT_J1_ESF: begin
					if (rx.is_dl && !rx.bit_val) begin
						yel_now = tjad_sat8(s_reg.yel_cnt);
					end
				end
				default: yel_now = s_reg.yel_cnt;
			endcase
		end
	end

	// Per-window verdicts
	always_comb begin
		blue_bad = zero_now < `TJAD_BLUE_ZEROS;
		blue_good = zero_now > (`TJAD_BLUE_ZEROS - 7'd1);
		case (s_reg.fmt)
			`TJAD_FMT_T1_ESF: begin
				yel_bad = yel_now > `TJAD_ESF_MATCHES;
				yel_good = yel_now < (`TJAD_ESF_MATCHES + 8'd1);
			end
			`TJAD_FMT_T1_DM: begin
				yel_bad = yel_now < `TJAD_DM_ONES;
				yel_good = yel_now > (`TJAD_DM_ONES - 8'd1);
			end
			`TJAD_FMT_J1_SF: begin
				yel_bad = yel_now < `TJAD_J1SF_ZEROS;
				yel_good = yel_now > (`TJAD_J1SF_ZEROS - 8'd1);
			end
			`TJAD_FMT_J1_ESF: begin
				yel_bad = yel_now < `TJAD_J1ESF_ZEROS;
				yel_good = yel_now > (`TJAD_J1ESF_ZEROS - 8'd1);
			end
			default: begin
				yel_bad = yel_now < `TJAD_SF_ONES;
				yel_good = yel_now > (`TJAD_SF_ONES - 8'd1);
			end
		endcase
		// A window that ends out of sync leaves yellow untouched
		yel_tick = win_end && rx.in_sync;
		red_bad = lost_now;
		red_good = sync_now;
		red_clr_th = 10'(s_reg.red_cth) * `TJAD_RED_CLR_MULT;
	end

	// Registers, window counters, flags and interrupt
	always_comb begin
		s_next = s_reg;
		s_next.rdata = 8'h00;
		s_next.zero_cnt = zero_now;
		s_next.yel_cnt = yel_now;
		s_next.dl_shift = dl_now;
		s_next.lost_all = lost_now;
		s_next.sync_all = sync_now;
		if (rx.frame_strobe) begin
			s_next.frame_cnt = s_reg.frame_cnt + 9'd1;
		end
		if (win_end) begin
			// Fresh counts for the next window
			s_next.frame_cnt = 9'd0;
			s_next.zero_cnt = 7'd0;
			s_next.yel_cnt = 8'd0;
			s_next.lost_all = 1'b1;
			s_next.sync_all = 1'b1;
		end
		if (bus.wr) begin
			case (bus.addr)
				`TJAD_ADDR_ENABLE: s_next.enable = bus.wdata[2:0];
				`TJAD_ADDR_FLAGS: s_next.flags = s_reg.flags & ~bus.wdata[2:0];
				`TJAD_ADDR_RED_DTH: s_next.red_dth = bus.wdata;
				`TJAD_ADDR_RED_CTH: s_next.red_cth = bus.wdata;
				`TJAD_ADDR_YEL_DTH: s_next.yel_dth = bus.wdata;
				`TJAD_ADDR_YEL_CTH: s_next.yel_cth = bus.wdata;
				`TJAD_ADDR_BLUE_DTH: s_next.blue_dth = bus.wdata;
				`TJAD_ADDR_BLUE_CTH: s_next.blue_cth = bus.wdata;
				`TJAD_ADDR_FORMAT: s_next.fmt = bus.wdata[2:0];
				default: s_next.fmt = s_reg.fmt;
			endcase
		end
		// Toggle beats a same-cycle clear, so no change is lost
		s_next.prev_alarm = status;
		s_next.flags = s_next.flags | (status ^ s_reg.prev_alarm);
		s_next.irq = |(s_next.flags & s_next.enable);
		if (bus.rd) begin
			case (bus.addr)
				`TJAD_ADDR_STATUS: s_next.rdata = {5'h00, status};
				`TJAD_ADDR_ENABLE: s_next.rdata = {5'h00, s_reg.enable};
				`TJAD_ADDR_FLAGS: s_next.rdata = {5'h00, s_reg.flags};
				`TJAD_ADDR_RED_DTH: s_next.rdata = s_reg.red_dth;
				`TJAD_ADDR_RED_CTH: s_next.rdata = s_reg.red_cth;
				`TJAD_ADDR_YEL_DTH: s_next.rdata = s_reg.yel_dth;
				`TJAD_ADDR_YEL_CTH: s_next.rdata = s_reg.yel_cth;
				`TJAD_ADDR_BLUE_DTH: s_next.rdata = s_reg.blue_dth;
				`TJAD_ADDR_BLUE_CTH: s_next.rdata = s_reg.blue_cth;
				`TJAD_ADDR_FORMAT: s_next.rdata = {5'h00, s_reg.fmt};
				default: s_next.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			s_reg <= '0;
			s_reg.enable <= 3'h0;
			s_reg.red_dth <= `TJAD_RST_RED_DTH;
			s_reg.red_cth <= `TJAD_RST_RED_CTH;
			s_reg.yel_dth <= `TJAD_RST_YEL_DTH;
			s_reg.yel_cth <= `TJAD_RST_YEL_CTH;
			s_reg.blue_dth <= `TJAD_RST_BLUE_DTH;
			s_reg.blue_cth <= `TJAD_RST_BLUE_CTH;
			s_reg.fmt <= `TJAD_FMT_T1_SF;
			s_reg.lost_all <= 1'b1;
			s_reg.sync_all <= 1'b1;
		end else if (clk_en) begin
			s_reg <= s_next;
		end
	end

	// Blue alarm
	tjad_persist #(.CW(10)) u_blue (
		.clock(clock),
		.rst(rst),
		.clk_en(clk_en),
		.tick(win_end),
		.bad(blue_bad),
		.good(blue_good),
		.declare_th({2'b00, s_reg.blue_dth}),
		.clear_th({2'b00, s_reg.blue_cth}),
		.alarm(blue_alarm)
	);

	// Yellow alarm
	tjad_persist #(.CW(10)) u_yel (
		.clock(clock),
		.rst(rst),
		.clk_en(clk_en),
		.tick(yel_tick),
		.bad(yel_bad),
		.good(yel_good),
		.declare_th({2'b00, s_reg.yel_dth}),
		.clear_th({2'b00, s_reg.yel_cth}),
		.alarm(yel_alarm)
	);

	// Red alarm; clear counted in 40 ms windows, three per 120 ms
	tjad_persist #(.CW(10)) u_red (
		.clock(clock),
		.rst(rst),
		.clk_en(clk_en),
		.tick(win_end),
		.bad(red_bad),
		.good(red_good),
		.declare_th({2'b00, s_reg.red_dth}),
		.clear_th(red_clr_th),
		.alarm(red_alarm)
	);

	assign rdata = s_reg.rdata;
	assign alarm_state = status;
	assign irq = s_reg.irq;

endmodule : tjad_alarm_detector
`default_nettype wire

// ### verilog/tjad_cfg.svh
// Offsets, reset values, field positions and counts for the alarm detector.
// Assumes an 8-bit register port and a framer that flags each received bit.
`ifndef TJAD_CFG_SVH
`define TJAD_CFG_SVH

`define TJAD_ADDR_STATUS 8'hb9
`define TJAD_ADDR_ENABLE 8'hba
`define TJAD_ADDR_FLAGS 8'hbb
`define TJAD_ADDR_RED_DTH 8'hbc
`define TJAD_ADDR_RED_CTH 8'hbd
`define TJAD_ADDR_YEL_DTH 8'hbe
`define TJAD_ADDR_YEL_CTH 8'hbf
`define TJAD_ADDR_BLUE_DTH 8'hc0
`define TJAD_ADDR_BLUE_CTH 8'hc1
`define TJAD_ADDR_FORMAT 8'hc8

`define TJAD_RST_RED_DTH 8'h3f
`define TJAD_RST_RED_CTH 8'h7f
`define TJAD_RST_YEL_DTH 8'h0a
`define TJAD_RST_YEL_CTH 8'h0a
`define TJAD_RST_BLUE_DTH 8'h3f
`define TJAD_RST_BLUE_CTH 8'h3f

`define TJAD_BIT_BLUE 2
`define TJAD_BIT_YEL 1
`define TJAD_BIT_RED 0

`define TJAD_FMT_T1_SF 3'h0
`define TJAD_FMT_T1_ESF 3'h1
`define TJAD_FMT_T1_DM 3'h2
`define TJAD_FMT_J1_SF 3'h3
`define TJAD_FMT_J1_ESF 3'h4
`define TJAD_FMT_SLC96 3'h5

`define TJAD_WIN_MS 40
`define TJAD_FRAME_US 125
`define TJAD_WIN_FRAMES (`TJAD_WIN_MS * 1000 / `TJAD_FRAME_US)
`define TJAD_RED_CLR_MULT 10'd3

`define TJAD_BLUE_ZEROS 7'd61
`define TJAD_SF_ONES 8'd77
`define TJAD_ESF_PATTERN 16'hff00
`define TJAD_ESF_MATCHES 8'd7
`define TJAD_DM_ONES 8'd4
`define TJAD_J1SF_ZEROS 8'd4
`define TJAD_J1ESF_ZEROS 8'd3

`define TJAD_BIT2_IDX 3'd1
`define TJAD_YBIT_IDX 3'd5
`define TJAD_YBIT_CHAN 5'd24
`define TJAD_J1_FRAME 5'd12

`endif

// ### verilog/tjad_persist.sv
// Window persistence counter for one alarm.
// Assumes one tick per evaluation window, on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "tjad_cfg.svh"
module tjad_persist #(
	parameter int CW = 10
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic clk_en,
	input wire logic tick,
	input wire logic bad,
	input wire logic good,
	input wire logic [CW-1:0] declare_th,
	input wire logic [CW-1:0] clear_th,
	output logic alarm
);
	import tjad_pkg::*;

	typedef struct packed {
		tjad_pst_t st;
		logic [CW-1:0] dcnt;
		logic [CW-1:0] ccnt;
	} tjad_pers_t;

	tjad_pers_t s_reg;
	tjad_pers_t s_next;

	always_comb begin
		s_next = s_reg;
		if (tick) begin
			case (s_reg.st)
				PS_CLEAR: begin
					s_next.ccnt = '0;
					// A passing window restarts the run
					s_next.dcnt = bad ? s_reg.dcnt + 1'b1 : '0;
					// Zero threshold acts as one window
					if (bad && (s_reg.dcnt + 1'b1 >= declare_th)) begin
						s_next.st = PS_SET;
						s_next.dcnt = '0;
					end
				end
				PS_SET: begin
					s_next.dcnt = '0;
					s_next.ccnt = good ? s_reg.ccnt + 1'b1 : '0;
					if (good && (s_reg.ccnt + 1'b1 >= clear_th)) begin
						s_next.st = PS_CLEAR;
						s_next.ccnt = '0;
					end
				end
				default: s_next.st = PS_CLEAR;
			endcase
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			s_reg <= '{st: PS_CLEAR, dcnt: '0, ccnt: '0};
		end else if (clk_en) begin
			s_reg <= s_next;
		end
	end

	assign alarm = (s_reg.st == PS_SET);

endmodule : tjad_persist
`default_nettype wire

// ### verilog/tjad_pkg.sv
// Types shared by the alarm detector and its persistence counter.
// Assumes tjad_cfg.svh is on the include path.
package tjad_pkg;

	typedef enum logic {PS_CLEAR, PS_SET} tjad_pst_t;

	// One received bit as the framer flags it
	typedef struct packed {
		logic in_sync;
		logic frame_strobe;
		logic bit_strobe;
		logic bit_val;
		logic is_fbit;
		logic is_dl;
		logic [4:0] frame_no;
		logic [4:0] chan;
		logic [2:0] bit_idx;
	} tjad_rx_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} tjad_bus_t;

	function automatic logic [7:0] tjad_sat8(input logic [7:0] v);
		tjad_sat8 = (v == 8'hff) ? v : v + 8'h01;
	endfunction : tjad_sat8

endpackage : tjad_pkg
